// file: src/dll_status_pkg.sv
package dll_status_pkg;
  localparam logic [1:0] CFG_OFFSET = 2'h0;
  localparam logic [1:0] VERNIER_OFFSET = 2'h1;
  localparam logic [1:0] TAP_OFFSET = 2'h2;
  localparam logic [1:0] STATUS_OFFSET = 2'h3;
  localparam int CFG_LOCK_HOLD_BIT = 0;
  localparam int CFG_VERN_EN_BIT = 1;
  localparam int CFG_IRQ_EN_BIT = 2;
  localparam int CFG_OVERRIDE_BIT = 4;
  localparam int CFG_RESERVED_BIT = 5;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] CFG_WRITE_MASK = 8'h37;
  localparam logic [7:0] VERNIER_RESET = 8'h00;
  localparam logic [7:0] TAP_RESET = 8'h00;
  localparam logic [7:0] TAP_MAX = 8'hFF;
  localparam logic [7:0] TAP_MIN = 8'h00;
  localparam int LOCK_LIMIT_CYCLES = 12 * 256;
  localparam int RELOCK_LIMIT_CYCLES = 24 * 256;
  localparam int TAP_COUNT = 256;
  localparam logic [3:0] STEP_CYCLES = 4'(LOCK_LIMIT_CYCLES / TAP_COUNT);
  localparam logic [3:0] MOVE_FLAG_CYCLES = 4'h8;

  typedef struct packed {
    logic go;
    logic rd_wrb;
    logic [1:0] addr;
    logic [7:0] wdata;
  } port_req_t;

  typedef struct packed {
    logic lead;
    logic lag;
    logic zero;
  } phase_det_t;

  typedef struct packed {
    logic sys_clock_activity_event;
    logic ref_clock_activity_event;
    logic range_fault_event;
    logic tap_move_event;
    logic unused;
    logic range_flag;
    logic tap_move_flag;
    logic lock_flag;
  } status_t;
endpackage : dll_status_pkg

// file: src/dll_lock_status_events.sv
// What this block does
// - Status register at 0x03 holds events and flags
// - Lock flag means zero phase tap found
// - Lock reads zero after reset, sets on lock
// - Lock reached within 12 times 256 cycles
// - Only resets clear lock; tap write resets
// - Tap move flag high eight cycles
// - Range flag sets stepping past line end
// - Range flag clears when lock recaptured
// - Tap move event sets on flag rise
// - Status read clears tap move event
// - Range event sets on range flag rise
// - Status read clears range event
// - Interrupt follows range event when enabled
// - Reference clock rise sets sticky event
// - System clock rise sets sticky event
// - Interrupt enable is bit 2 of 0x00
// - Tap register write starts soft reset, relock
// - Busy set starts command; device clears it
`timescale 1ns/1ps
`default_nettype none
module dll_lock_status_events
  import dll_status_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic system_clock_in,
  input wire logic reference_clock_in,
  input wire phase_det_t phase_det,
  input wire port_req_t port_req,
  output logic [7:0] port_rdata,
  output logic port_busy_bit,
  output logic irq_out,
  output logic [7:0] tap_out,
  output logic bypass_out
);
  typedef enum logic {S_TRACK, S_SEEK_ZERO} loop_state_t;

  loop_state_t state_r, state_nxt;
  logic [7:0] cfg_r, cfg_nxt, vernier_r, vernier_nxt, tap_r, tap_nxt, rdata_r, rdata_nxt;
  logic busy_r, busy_nxt, rd_wrb_r, rd_wrb_nxt;
  logic [1:0] addr_r, addr_nxt;
  logic [7:0] wdata_r, wdata_nxt;
  logic [3:0] step_cnt_r, step_cnt_nxt, move_cnt_r, move_cnt_nxt;
  logic lock_r, lock_nxt, range_r, range_nxt, move_flag_r, move_flag_nxt;
  logic sys_prev_r, ref_prev_r;
  logic [3:0] ev_r, ev_nxt;
  logic irq_r, irq_nxt, bypass_r, bypass_nxt;
  logic step_en, exec, status_read, soft_reset, moved;
  logic [3:0] ev_set;
  status_t status;

  assign step_en = (step_cnt_r == STEP_CYCLES - 4'h1);
  assign exec = busy_r;
  assign status_read = exec && rd_wrb_r && (addr_r == STATUS_OFFSET);
  assign soft_reset = exec && !rd_wrb_r && (addr_r == TAP_OFFSET);
  assign status = '{ev_r[3], ev_r[2], ev_r[1], ev_r[0], 1'b0, range_r, move_flag_r, lock_r};

  // Indirect port: command taken with go, executed one cycle later
  always_comb begin
    busy_nxt = busy_r;
    rd_wrb_nxt = rd_wrb_r;
    addr_nxt = addr_r;
    wdata_nxt = wdata_r;
    cfg_nxt = cfg_r;
    vernier_nxt = vernier_r;
    rdata_nxt = rdata_r;
    if (exec) begin
      busy_nxt = 1'b0;
      if (rd_wrb_r) begin
        case (addr_r)
          CFG_OFFSET: rdata_nxt = cfg_r;
          VERNIER_OFFSET: rdata_nxt = vernier_r;
          TAP_OFFSET: rdata_nxt = tap_r;
          default: rdata_nxt = status;
        endcase
      end else if (addr_r == CFG_OFFSET) begin
        cfg_nxt = wdata_r & CFG_WRITE_MASK;
      end else if (addr_r == VERNIER_OFFSET) begin
        vernier_nxt = wdata_r;
      end
    end else if (port_req.go) begin
      busy_nxt = 1'b1;
      rd_wrb_nxt = port_req.rd_wrb;
      addr_nxt = port_req.addr;
      wdata_nxt = port_req.wdata;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy_r <= 1'b0;
      rd_wrb_r <= 1'b0;
      addr_r <= 2'h0;
      wdata_r <= 8'h00;
      cfg_r <= CFG_RESET;
      vernier_r <= VERNIER_RESET;
      rdata_r <= 8'h00;
    end else begin
      busy_r <= busy_nxt;
      rd_wrb_r <= rd_wrb_nxt;
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
      cfg_r <= cfg_nxt;
      vernier_r <= vernier_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Delay loop: one tap step per STEP_CYCLES so 256 taps fit the lock budget
  always_comb begin
    state_nxt = state_r;
    tap_nxt = tap_r;
    lock_nxt = lock_r;
    range_nxt = range_r;
    step_cnt_nxt = step_en ? 4'h0 : step_cnt_r + 4'h1;
    if (soft_reset) begin
      state_nxt = S_SEEK_ZERO;
      lock_nxt = 1'b0;
      step_cnt_nxt = 4'h0;
    end else if (cfg_r[CFG_VERN_EN_BIT]) begin
      tap_nxt = vernier_r;
    end else if (step_en) begin
      case (state_r)
        S_SEEK_ZERO: begin
          if (tap_r == TAP_MIN) begin
            state_nxt = S_TRACK;
          end else begin
            tap_nxt = tap_r - 8'h01;
          end
        end
        S_TRACK: begin
          // Hold mode freezes the tap once locked
          if (!(cfg_r[CFG_LOCK_HOLD_BIT] && lock_r)) begin
            if (phase_det.zero) begin
              lock_nxt = 1'b1;
              range_nxt = 1'b0;
            end else if (phase_det.lead) begin
              if (tap_r == TAP_MAX) begin
                range_nxt = 1'b1;
              end else begin
                tap_nxt = tap_r + 8'h01;
              end
            end else if (phase_det.lag) begin
              if (tap_r == TAP_MIN) begin
                range_nxt = 1'b1;
              end else begin
                tap_nxt = tap_r - 8'h01;
              end
            end
          end
        end
        default: state_nxt = S_TRACK;
      endcase
    end
  end

  assign moved = (tap_nxt != tap_r);

  // Tap move flag, event bits and interrupt
  always_comb begin
    move_cnt_nxt = moved ? MOVE_FLAG_CYCLES : (move_cnt_r != 4'h0 ? move_cnt_r - 4'h1 : 4'h0);
    move_flag_nxt = (move_cnt_nxt != 4'h0);
    ev_set[0] = move_flag_nxt && !move_flag_r;
    ev_set[1] = range_nxt && !range_r;
    ev_set[2] = reference_clock_in && !ref_prev_r;
    ev_set[3] = system_clock_in && !sys_prev_r;
    ev_nxt = (status_read ? 4'h0 : ev_r) | ev_set;
    irq_nxt = ev_nxt[1] && cfg_r[CFG_IRQ_EN_BIT];
    bypass_nxt = cfg_r[CFG_OVERRIDE_BIT];
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= S_TRACK;
      tap_r <= TAP_RESET;
      lock_r <= 1'b0;
      range_r <= 1'b0;
      step_cnt_r <= 4'h0;
      move_cnt_r <= 4'h0;
      move_flag_r <= 1'b0;
      sys_prev_r <= 1'b0;
      ref_prev_r <= 1'b0;
      ev_r <= 4'h0;
      irq_r <= 1'b0;
      bypass_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      tap_r <= tap_nxt;
      lock_r <= lock_nxt;
      range_r <= range_nxt;
      step_cnt_r <= step_cnt_nxt;
      move_cnt_r <= move_cnt_nxt;
      move_flag_r <= move_flag_nxt;
      sys_prev_r <= system_clock_in;
      ref_prev_r <= reference_clock_in;
      ev_r <= ev_nxt;
      irq_r <= irq_nxt;
      bypass_r <= bypass_nxt;
    end
  end

  assign port_rdata = rdata_r;
  assign port_busy_bit = busy_r;
  assign irq_out = irq_r;
  assign tap_out = tap_r;
  assign bypass_out = bypass_r;

  sequence move_seen;
    tap_r != $past(tap_r);
  endsequence

  a_move_flag_len: assert property (@(posedge clk) disable iff (!rstn)
    move_seen |-> move_flag_r [*8] ##1 (!move_flag_r or move_seen))
    else $error("tap move flag not held eight cycles");
  a_lock_sticky: assert property (@(posedge clk) disable iff (!rstn)
    lock_r && !$past(soft_reset) |-> $past(lock_r) || $past(phase_det.zero))
    else $error("lock flag set without lock");
  a_lock_clear: assert property (@(posedge clk) disable iff (!rstn)
    $fell(lock_r) |-> $past(soft_reset))
    else $error("lock flag cleared without reset");
  a_move_event: assert property (@(posedge clk) disable iff (!rstn)
    $rose(move_flag_r) |-> ev_r[0])
    else $error("tap move event not set");
  a_range_event: assert property (@(posedge clk) disable iff (!rstn)
    $rose(range_r) |-> ev_r[1])
    else $error("range event not set");
  a_read_clear: assert property (@(posedge clk) disable iff (!rstn)
    status_read && !ev_set[0] |=> !ev_r[0])
    else $error("tap move event not cleared by read");
  a_range_clear: assert property (@(posedge clk) disable iff (!rstn)
    status_read && !ev_set[1] |=> !ev_r[1])
    else $error("range event not cleared by read");
  a_set_wins: assert property (@(posedge clk) disable iff (!rstn)
    status_read && ev_set[3] |=> ev_r[3])
    else $error("system clock event lost on read");
  a_ref_event: assert property (@(posedge clk) disable iff (!rstn)
    $rose(reference_clock_in) |=> ev_r[2])
    else $error("reference clock event missed");
  a_irq_gate: assert property (@(posedge clk) disable iff (!rstn)
    irq_r |-> $past(cfg_r[CFG_IRQ_EN_BIT]) && ev_r[1])
    else $error("interrupt without enabled range event");
  a_range_relock: assert property (@(posedge clk) disable iff (!rstn)
    $rose(lock_r) |-> !range_r)
    else $error("range flag survives lock capture");
  a_busy_done: assert property (@(posedge clk) disable iff (!rstn)
    $rose(port_busy_bit) |=> !port_busy_bit)
    else $error("busy not cleared after command");
  a_lock_time: assert property (@(posedge clk) disable iff (!rstn)
    state_r == S_TRACK && !lock_r && phase_det.zero && step_en && !soft_reset &&
    !cfg_r[CFG_VERN_EN_BIT] |=> lock_r)
    else $error("lock not taken at zero phase");
endmodule : dll_lock_status_events
`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import dll_status_pkg::*;
  typedef struct packed {logic [7:0] exp; logic [7:0] mask;} note_t;
  logic clk, rstn, sys_in, ref_in, irq_out, bypass_out, busy, busy_q;
  phase_det_t pd;
  port_req_t req;
  logic [7:0] rdata, tap_out, rv, t0;
  note_t notes[$];
  note_t nt;
  int err_total, cmp_count, n, hits, evs;
  integer seed;

  dll_lock_status_events dut_u (.clk(clk), .rstn(rstn), .system_clock_in(sys_in),
    .reference_clock_in(ref_in), .phase_det(pd), .port_req(req), .port_rdata(rdata),
    .port_busy_bit(busy), .irq_out(irq_out), .tap_out(tap_out), .bypass_out(bypass_out));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t data %h expected %h", $time, got, exp);
    end
  endtask : cmp8

  task automatic cmp1(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t flag %b expected %b", $time, got, exp);
    end
  endtask : cmp1

  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude

  // Go only while busy is low, so accesses run every two cycles
  task automatic access(input logic rd, input logic [1:0] a, input logic [7:0] wd,
                        input logic [7:0] ex, input logic [7:0] mk);
    notes.push_back({ex, mk});
    req = {1'b1, rd, a, wd};
    @(negedge clk);
    req.go = 1'b0;
    @(negedge clk);
  endtask : access

  // Read data updates on the same edge that busy falls
  always @(negedge clk) begin
    if (busy_q === 1'b1 && busy === 1'b0 && notes.size() > 0) begin
      nt = notes.pop_front();
      if (nt.mask != 8'h00) cmp8(rdata & nt.mask, nt.exp & nt.mask);
    end
    busy_q = busy;
  end

  task automatic wait_tap(input logic [7:0] t, input logic eq);
    n = 0;
    while (((tap_out === t) == eq) && n < 8000) begin
      @(negedge clk);
      n++;
    end
  endtask : wait_tap

  initial begin
    seed = 32'h7E60EF9D;
    rstn = 1'b0;
    req = '0;
    sys_in = 1'b0;
    ref_in = 1'b0;
    pd = 3'h0;
    repeat (12) @(negedge clk);
    rstn = 1'b1;
    access(1'b1, STATUS_OFFSET, 8'h00, 8'h00, 8'hFF);
    access(1'b1, CFG_OFFSET, 8'h00, CFG_RESET, 8'hFF);
    rv = 8'($random(seed));
    access(1'b0, VERNIER_OFFSET, rv, 8'h00, 8'h00);
    access(1'b1, VERNIER_OFFSET, 8'h00, rv, 8'hFF);
    for (int i = 0; i < 2; i++) begin
      if (i == 0) ref_in = 1'b1;
      else sys_in = 1'b1;
      @(negedge clk);
      access(1'b1, STATUS_OFFSET, 8'h00, (i == 0) ? 8'h40 : 8'h80, 8'hC0);
      access(1'b1, STATUS_OFFSET, 8'h00, 8'h00, 8'hC0);
      ref_in = 1'b0;
      sys_in = 1'b0;
    end
    // Rise in the clearing cycle must survive the read
    fork
      access(1'b1, STATUS_OFFSET, 8'h00, 8'h00, 8'h80);
      begin
        @(negedge clk);
        sys_in = 1'b1;
      end
    join
    access(1'b1, STATUS_OFFSET, 8'h00, 8'h80, 8'h80);
    sys_in = 1'b0;
    // One tap step up, then aligned: flag window seen by reads every 2 cycles
    t0 = tap_out;
    pd = 3'h4;
    wait_tap(t0, 1'b1);
    pd = 3'h1;
    cmp8(tap_out, t0 + 8'h01);
    hits = 0;
    evs = 0;
    repeat (10) begin
      access(1'b1, STATUS_OFFSET, 8'h00, 8'h00, 8'h00);
      hits += int'(rdata[1]);
      evs += int'(rdata[4]);
    end
    cmp8(8'(hits), 8'h04);
    cmp8(8'(evs), 8'h01);
    access(1'b1, STATUS_OFFSET, 8'h00, 8'h01, 8'h0F);
    // Range fault with interrupt disabled, then enabled
    for (int k = 0; k < 2; k++) begin
      access(1'b0, TAP_OFFSET, 8'h00, 8'h00, 8'h00);
      pd = 3'h2;
      access(1'b1, STATUS_OFFSET, 8'h00, 8'h00, 8'h01);
      wait_tap(8'h00, 1'b0);
      n = 0;
      while (irq_out !== 1'b1 && n < 40) begin
        @(negedge clk);
        n++;
      end
      cmp1(irq_out, k[0]);
      access(1'b1, STATUS_OFFSET, 8'h00, 8'h24, 8'h2D);
      access(1'b1, STATUS_OFFSET, 8'h00, 8'h04, 8'h2D);
      cmp1(irq_out, 1'b0);
      if (k == 0) access(1'b0, CFG_OFFSET, 8'h04, 8'h00, 8'h00);
      access(1'b1, CFG_OFFSET, 8'h00, 8'h04, 8'hFF);
      cmp1(irq_out, 1'b0);
      pd = 3'h1;
      repeat (15) @(negedge clk);
      access(1'b1, STATUS_OFFSET, 8'h00, 8'h01, 8'h0D);
    end
    // Hold freezes a locked tap; lock survives it
    t0 = tap_out;
    access(1'b0, CFG_OFFSET, 8'h01, 8'h00, 8'h00);
    pd = 3'h4;
    repeat (15) @(negedge clk);
    cmp8(tap_out, t0);
    access(1'b1, STATUS_OFFSET, 8'h00, 8'h01, 8'h01);
    pd = 3'h0;
    // Vernier drives the tap directly
    access(1'b0, CFG_OFFSET, 8'h02, 8'h00, 8'h00);
    access(1'b1, TAP_OFFSET, 8'h00, rv, 8'hFF);
    cmp8(tap_out, rv);
    cmp1(bypass_out, 1'b0);
    // Config bits 3, 6 and 7 drop, reserved bit 5 is kept; override reaches the bypass output
    access(1'b0, CFG_OFFSET, 8'hF8, 8'h00, 8'h00);
    access(1'b1, CFG_OFFSET, 8'h00, 8'h30, 8'hFF);
    cmp1(bypass_out, 1'b1);
    conclude();
  end

  // Whole run needs well under 20000 cycles
  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    conclude();
  end
endmodule : tb_top
`default_nettype wire
